/* File: hdl/bit_sync.sv */
// two flip-flop synchroniser for slow levels
`timescale 1ns/10ps
module bit_sync #(
   parameter int W = 1
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic en,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta;

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         meta <= '0;
         q <= '0;
      end else if (en) begin
         meta <= d;
         q <= meta;
      end
   end
endmodule

/* File: hdl/guard_pkg.sv */
// constants and types shared by the serial port access guard
//
// Contract
// - capture master command byte into read-only register
// - port enable routes link onto four shared pins
// - safe mode permits only command and ram window (code limits writes and link erase only; reads of any address still go out)
// - safe mode discards writes outside permitted targets
// - security lock refuses external flash reads
// - security lock blocks page zero and engine erasure
package guard_pkg;
   // register offsets and bit positions
   localparam logic [15:0] ADDR_LOCK = 16'h00b2;
   localparam int LOCK_BIT = 6;
   localparam logic [15:0] ADDR_CMD = 16'h00fd;
   localparam logic [15:0] ADDR_PORT = 16'h270c;
   localparam int PORT_EN_BIT = 4;
   localparam int SAFE_BIT = 3;
   localparam logic [15:0] ADDR_STAT = 16'h2710;
   localparam int STAT_WR_BIT = 0;
   localparam int STAT_RD_BIT = 1;
   localparam int STAT_ER_BIT = 2;
   localparam int STAT_ACT_BIT = 7;
   // reset values
   localparam logic RST_PORT_EN = 1'b1;
   localparam logic RST_SAFE = 1'b0;
   localparam logic RST_LOCK = 1'b0;
   localparam logic [7:0] RST_CMD = 8'h00;
   localparam logic [7:0] RST_BYTE = 8'h00;
   // command byte fields
   localparam int CMD_RD_BIT = 7;
   localparam int CMD_FLASH_BIT = 6;
   localparam logic [7:0] CMD_ERASE = 8'h60;
   // ram window left open in safe mode
   localparam logic [15:0] WIN_BASE = 16'h0000;
   localparam logic [15:0] WIN_BYTES = 16'h0010;
   localparam int PAGE_BITS = 7;
   // shared pin positions
   localparam int PIN_CS = 0;
   localparam int PIN_MOSI = 2;
   localparam int PIN_MISO = 3;
   typedef enum {ST_IDLE, ST_CMD, ST_AHI, ST_ALO, ST_DATA} frame_state_t;
endpackage

/* File: hdl/spi_link.sv */
// shifter running on the master's serial clock
`timescale 1ns/10ps
module spi_link (
   input wire logic spi_clk,
   input wire logic rstn,
   input wire logic frame_rstn,
   input wire logic mosi,
   input wire logic [7:0] resp_data,
   input wire logic resp_tog,
   output logic [7:0] byte_data,
   output logic byte_tog,
   output logic miso
);
   import guard_pkg::*;
   logic [2:0] bit_cnt;
   logic [6:0] shift;
   logic [7:0] tx;
   logic resp_meta;
   logic resp_sync;
   logic resp_ack;

   // bit position is cleared by the frame's own select
   always_ff @(posedge spi_clk or negedge frame_rstn) begin
      if (!frame_rstn) begin
         bit_cnt <= '0;
         shift <= '0;
      end else begin
         bit_cnt <= bit_cnt + 3'd1;
         shift <= {shift[5:0], mosi};
      end
   end

   // completed byte is held until the next one and announced by toggle
   always_ff @(posedge spi_clk or negedge rstn) begin
      if (!rstn) begin
         byte_data <= RST_BYTE;
         byte_tog <= 1'b0;
      end else if (bit_cnt == 3'd7) begin
         byte_data <= {shift, mosi};
         byte_tog <= ~byte_tog;
      end
   end

   // answer byte enters through a toggle handshake
   always_ff @(posedge spi_clk or negedge rstn) begin
      if (!rstn) begin
         resp_meta <= 1'b0;
         resp_sync <= 1'b0;
         resp_ack <= 1'b0;
         tx <= RST_BYTE;
      end else begin
         resp_meta <= resp_tog;
         resp_sync <= resp_meta;
         if (bit_cnt == 3'd7) begin
            resp_ack <= resp_sync;
            tx <= (resp_sync != resp_ack) ? resp_data : RST_BYTE;
         end else begin
            tx <= {tx[6:0], 1'b0};
         end
      end
   end

   // output changes on the falling edge, sampled by master on rising
   always_ff @(negedge spi_clk or negedge rstn) begin
      if (!rstn) begin
         miso <= 1'b0;
      end else begin
         miso <= tx[7];
      end
   end
endmodule

/* File: hdl/spi_slave_access_guard.sv */
// serial slave port access guard: command capture, pin sharing, safe mode, flash lock
//
// Strobed register access is this design's own decision.
`timescale 1ns/10ps
module spi_slave_access_guard (
   input wire logic ref_clk,
   input wire logic rstn,
   input wire logic ce,
   input wire logic [15:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   input wire logic spi_clk,
   input wire logic [3:0] seg_in,
   output logic [3:0] seg_out,
   output logic [3:0] seg_oe,
   input wire logic [3:0] lcd_seg_out,
   input wire logic [3:0] segment_pin_map,
   output logic [15:0] mem_addr,
   output logic [7:0] mem_wdata,
   output logic mem_wr,
   output logic mem_rd,
   output logic mem_flash,
   input wire logic [7:0] mem_rdata,
   input wire logic [guard_pkg::PAGE_BITS-1:0] engine_code_location,
   input wire logic cpu_erase_req,
   input wire logic [guard_pkg::PAGE_BITS-1:0] cpu_erase_page,
   output logic erase_req,
   output logic [guard_pkg::PAGE_BITS-1:0] erase_page,
   output logic erase_deny,
   input wire logic ice_rd_req,
   output logic ice_rd_grant,
   output logic ice_rd_deny
);
   import guard_pkg::*;

   ////////////////////////////////////////////////////////////////////////////////
   // declarations
   logic serial_port_enable, serial_write_guard, flash_security_lock;
   logic [7:0] spi_command_byte, status, link_byte, resp_data, addr_hi, next_rdata;
   frame_state_t state;
   logic frame_rstn, link_tog, link_miso, resp_tog;
   logic [2:0] pin_sync;
   logic byte_seen, byte_evt, cs_active;
   logic [15:0] cur_addr;
   logic rd_pend, rd_refused, set_wr_ref, set_rd_ref, set_er_ref;
   logic cmd_read, cmd_flash, cmd_erase, spi_erase_ok, cpu_erase_ok;

   ////////////////////////////////////////////////////////////////////////////////
   // decoding functions
   function automatic logic in_window(input logic [15:0] a);
      in_window = (a >= WIN_BASE) && (a < 16'(WIN_BASE + WIN_BYTES));
   endfunction

   function automatic logic erase_allowed(input logic [PAGE_BITS-1:0] page,
                                          input logic [PAGE_BITS-1:0] loc, input logic lock);
      erase_allowed = !lock || ((page != '0) && (page < loc));
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // link side and crossings
   assign frame_rstn = rstn & serial_port_enable & ~seg_in[PIN_CS];

   spi_link u_link (
      .spi_clk(spi_clk),
      .rstn(rstn),
      .frame_rstn(frame_rstn),
      .mosi(seg_in[PIN_MOSI]),
      .resp_data(resp_data),
      .resp_tog(resp_tog),
      .byte_data(link_byte),
      .byte_tog(link_tog),
      .miso(link_miso)
   );

   bit_sync #(.W(3)) u_sync (
      .clk(ref_clk),
      .rstn(rstn),
      .en(ce),
      .d({link_tog, link_miso, ~seg_in[PIN_CS]}),
      .q(pin_sync)
   );

   assign cs_active = pin_sync[0] & serial_port_enable;
   assign byte_evt = (pin_sync[2] != byte_seen) & cs_active;
   assign cmd_read = spi_command_byte[CMD_RD_BIT];
   assign cmd_flash = spi_command_byte[CMD_FLASH_BIT];
   assign cmd_erase = (spi_command_byte == CMD_ERASE);

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         byte_seen <= 1'b0;
      end else if (ce) begin
         byte_seen <= pin_sync[2];
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // frame sequencing
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         state <= ST_IDLE;
      end else if (ce) begin
         if (!cs_active) begin
            state <= ST_IDLE;
         end else begin
            case (state)
               ST_IDLE: state <= ST_CMD;
               ST_CMD: if (byte_evt) state <= ST_AHI;
               ST_AHI: if (byte_evt) state <= ST_ALO;
               ST_ALO: if (byte_evt) state <= ST_DATA;
               default: state <= ST_DATA;
            endcase
         end
      end
   end

   // command byte is taken in every mode, safe mode included
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         spi_command_byte <= RST_CMD;
      end else if (ce && byte_evt && state == ST_CMD) begin
         spi_command_byte <= link_byte;
      end
   end

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         addr_hi <= 8'h00;
         cur_addr <= 16'h0000;
      end else if (ce && byte_evt) begin
         if (state == ST_AHI) begin
            addr_hi <= link_byte;
         end else if (state == ST_ALO) begin
            cur_addr <= 16'({addr_hi, link_byte} + {15'h0000, cmd_read});
         end else if (state == ST_DATA) begin
            cur_addr <= 16'(cur_addr + 16'h0001);
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // guarded memory requests
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         mem_addr <= 16'h0000;
         mem_wdata <= 8'h00;
         mem_wr <= 1'b0;
         mem_rd <= 1'b0;
         mem_flash <= 1'b0;
         set_wr_ref <= 1'b0;
         set_rd_ref <= 1'b0;
         rd_refused <= 1'b0;
      end else if (ce) begin
         mem_wr <= 1'b0;
         mem_rd <= 1'b0;
         set_wr_ref <= 1'b0;
         set_rd_ref <= 1'b0;
         rd_refused <= 1'b0;
         if (byte_evt && cmd_read && (state == ST_ALO || state == ST_DATA)) begin
            mem_addr <= (state == ST_ALO) ? {addr_hi, link_byte} : cur_addr;
            mem_flash <= cmd_flash;
            if (cmd_flash && flash_security_lock) begin
               set_rd_ref <= 1'b1;
               rd_refused <= 1'b1;
            end else begin
               mem_rd <= 1'b1;
            end
         end else if (byte_evt && !cmd_read && !cmd_erase && state == ST_DATA) begin
            mem_addr <= cur_addr;
            mem_wdata <= link_byte;
            mem_flash <= cmd_flash;
            if (serial_write_guard && (cmd_flash || !in_window(cur_addr))) begin
               set_wr_ref <= 1'b1;
            end else begin
               mem_wr <= 1'b1;
            end
         end
      end
   end

   // read answer goes back to the link by toggle, refused reads answer zero
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         rd_pend <= 1'b0;
         resp_data <= RST_BYTE;
         resp_tog <= 1'b0;
      end else if (ce) begin
         rd_pend <= mem_rd;
         if (rd_pend) begin
            resp_data <= mem_rdata;
            resp_tog <= ~resp_tog;
         end else if (rd_refused) begin
            resp_data <= RST_BYTE;
            resp_tog <= ~resp_tog;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // erase guard for link and processor requests
   assign spi_erase_ok = erase_allowed(link_byte[PAGE_BITS-1:0], engine_code_location,
                                       flash_security_lock) && !serial_write_guard;
   assign cpu_erase_ok = erase_allowed(cpu_erase_page, engine_code_location, flash_security_lock);

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         erase_req <= 1'b0;
         erase_page <= '0;
         erase_deny <= 1'b0;
         set_er_ref <= 1'b0;
      end else if (ce) begin
         erase_req <= 1'b0;
         erase_deny <= 1'b0;
         set_er_ref <= 1'b0;
         if (byte_evt && cmd_erase && state == ST_ALO) begin
            erase_page <= link_byte[PAGE_BITS-1:0];
            erase_req <= spi_erase_ok;
            set_er_ref <= !spi_erase_ok;
         end else if (cpu_erase_req) begin
            erase_page <= cpu_erase_page;
            erase_req <= cpu_erase_ok;
            erase_deny <= !cpu_erase_ok;
         end
      end
   end

   // emulation port flash reads
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         ice_rd_grant <= 1'b0;
         ice_rd_deny <= 1'b0;
      end else if (ce) begin
         ice_rd_grant <= ice_rd_req && !flash_security_lock;
         ice_rd_deny <= ice_rd_req && flash_security_lock;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // shared pins
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         seg_out <= 4'h0;
         seg_oe <= 4'h0;
      end else if (ce) begin
         if (serial_port_enable) begin
            seg_out <= {pin_sync[1], 3'b000};
            seg_oe <= {cs_active, 3'b000};
         end else begin
            seg_out <= lcd_seg_out;
            seg_oe <= 4'hf;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // register file
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         serial_port_enable <= RST_PORT_EN;
         serial_write_guard <= RST_SAFE;
      end else if (ce && reg_wr && reg_addr == ADDR_PORT) begin
         serial_port_enable <= reg_wdata[PORT_EN_BIT];
         serial_write_guard <= reg_wdata[SAFE_BIT];
      end
   end

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         flash_security_lock <= RST_LOCK;
      end else if (ce && reg_wr && reg_addr == ADDR_LOCK) begin
         flash_security_lock <= reg_wdata[LOCK_BIT];
      end
   end

   // refusal flags clear on write of one, a new refusal wins
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         status <= 8'h00;
      end else if (ce) begin
         status[STAT_ACT_BIT] <= cs_active;
         if (reg_wr && reg_addr == ADDR_STAT) begin
            status[STAT_WR_BIT] <= status[STAT_WR_BIT] & ~reg_wdata[STAT_WR_BIT];
            status[STAT_RD_BIT] <= status[STAT_RD_BIT] & ~reg_wdata[STAT_RD_BIT];
            status[STAT_ER_BIT] <= status[STAT_ER_BIT] & ~reg_wdata[STAT_ER_BIT];
         end
         if (set_wr_ref) status[STAT_WR_BIT] <= 1'b1;
         if (set_rd_ref) status[STAT_RD_BIT] <= 1'b1;
         if (set_er_ref) status[STAT_ER_BIT] <= 1'b1;
      end
   end

   always_comb begin
      next_rdata = 8'h00;
      if (reg_addr == ADDR_LOCK) begin
         next_rdata[LOCK_BIT] = flash_security_lock;
      end else if (reg_addr == ADDR_CMD) begin
         next_rdata = spi_command_byte;
      end else if (reg_addr == ADDR_PORT) begin
         next_rdata[PORT_EN_BIT] = serial_port_enable;
         next_rdata[SAFE_BIT] = serial_write_guard;
      end else if (reg_addr == ADDR_STAT) begin
         next_rdata = status;
      end
   end

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         reg_rdata <= 8'h00;
      end else if (ce) begin
         reg_rdata <= reg_rd ? next_rdata : 8'h00;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rstn);
   sequence s_cmd_byte;
      ce && byte_evt && state == ST_CMD;
   endsequence
   property p_cmd_capture;
      s_cmd_byte |=> spi_command_byte == $past(link_byte);
   endproperty
   a_cmd_capture: assert property (p_cmd_capture) else $error("command byte not captured");
   property p_pins_free;
      ce && !serial_port_enable |=> seg_oe == 4'hf && seg_out == $past(lcd_seg_out);
   endproperty
   a_pins_free: assert property (p_pins_free) else $error("segment pins not returned");
   property p_pins_link;
      ce && serial_port_enable |=> seg_oe[2:0] == 3'b000 && seg_oe[3] == $past(cs_active);
   endproperty
   a_pins_link: assert property (p_pins_link) else $error("shared pins not given to link");
   property p_safe_write;
      mem_wr |-> !$past(serial_write_guard) || (in_window(mem_addr) && !mem_flash);
   endproperty
   a_safe_write: assert property (p_safe_write) else $error("safe mode write escaped");
   sequence s_bad_write;
      ce && byte_evt && state == ST_DATA && !cmd_read && !cmd_erase && serial_write_guard
         && (cmd_flash || !in_window(cur_addr));
   endsequence
   sequence s_discard;
      !mem_wr ##1 status[STAT_WR_BIT];
   endsequence
   property p_discard;
      s_bad_write |=> s_discard;
   endproperty
   a_discard: assert property (p_discard) else $error("outside write not discarded");
   property p_flash_read;
      mem_rd |-> !mem_flash || !$past(flash_security_lock);
   endproperty
   a_flash_read: assert property (p_flash_read) else $error("locked flash read issued");
   property p_ice_read;
      ice_rd_grant |-> !$past(flash_security_lock) && $past(ice_rd_req);
   endproperty
   a_ice_read: assert property (p_ice_read) else $error("locked emulation read granted");
   property p_erase;
      erase_req |-> !$past(flash_security_lock)
         || (erase_page != '0 && erase_page < $past(engine_code_location));
   endproperty
   a_erase: assert property (p_erase) else $error("protected page erased");
endmodule

/* File: tb/spi_master_model.sv */
// serial bus master model driving frames onto the shared pins
`timescale 1ns/10ps
module spi_master_model (
   output logic spi_clk,
   output logic cs_n,
   output logic mosi,
   input wire logic miso
);
   initial begin
      spi_clk = 1'b0;
      cs_n = 1'b1;
      mosi = 1'b1;
   end
   ////////////////////////////////////////////////////////////////
   // mode 0, msb first, 80 ns bit time; clock stands low between frames
   task automatic frame(input int n, input logic [63:0] tx, output logic [63:0] rx);
      rx = '0;
      cs_n = 1'b0;
      for (int k = 0; k < n; k++) begin
         for (int b = 7; b >= 0; b--) begin
            mosi = tx[56-8*k+b];
            #40;
            spi_clk = 1'b1;
            rx[56-8*k+b] = miso;
            #40;
            spi_clk = 1'b0;
         end
      end
      #40;
      cs_n = 1'b1;
      // released line shows the inverse so a stale level is never trusted
      mosi = ~mosi;
      // select stays high three bit times between frames
      #240;
   endtask
endmodule

/* File: tb/tb.sv */
// self-checking bench for the serial port access guard
`timescale 1ns/10ps
module tb;
   import guard_pkg::*;
   logic ref_clk, rstn, ce, reg_wr, reg_rd, cpu_erase_req, ice_rd_req;
   logic [15:0] reg_addr, mem_addr, last_rd_addr;
   logic [7:0] reg_wdata, reg_rdata, mem_wdata, mem_rdata;
   logic [3:0] seg_out, seg_oe, lcd_seg_out;
   logic mem_wr, mem_rd, mem_flash, erase_req, erase_deny, ice_rd_grant, ice_rd_deny, rd_flash;
   logic [7:0] erase_seen;
   logic [PAGE_BITS-1:0] engine_code_location, cpu_erase_page, erase_page;
   logic spi_clk, cs_n, mosi;
   logic [63:0] rx;
   logic [23:0] wr_log [$];
   int failures, n_tests, cycles;

   spi_slave_access_guard i_spi_slave_access_guard (.ref_clk(ref_clk), .rstn(rstn), .ce(ce),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .spi_clk(spi_clk), .seg_in({1'b0, mosi, spi_clk, cs_n}), .seg_out(seg_out), .seg_oe(seg_oe),
      .lcd_seg_out(lcd_seg_out), .segment_pin_map(4'h0),
      .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_wr(mem_wr), .mem_rd(mem_rd), .mem_flash(mem_flash),
      .mem_rdata(mem_rdata), .engine_code_location(engine_code_location), .cpu_erase_req(cpu_erase_req),
      .cpu_erase_page(cpu_erase_page), .erase_req(erase_req), .erase_page(erase_page),
      .erase_deny(erase_deny), .ice_rd_req(ice_rd_req), .ice_rd_grant(ice_rd_grant),
      .ice_rd_deny(ice_rd_deny));

   spi_master_model master (.spi_clk(spi_clk), .cs_n(cs_n), .mosi(mosi), .miso(seg_out[3]));

   initial begin
      ref_clk = 1'b0;
      forever #2.5 ref_clk = ~ref_clk;
   end
   ////////////////////////////////////////////////////////////////
   // memory request log and timeout
   always @(posedge ref_clk) begin
      cycles++;
      if (mem_wr === 1'b1) wr_log.push_back({mem_addr, mem_wdata});
      if (mem_rd === 1'b1 && last_rd_addr === 16'hffff) begin
         last_rd_addr = mem_addr;
         rd_flash = mem_flash;
      end
      if (erase_req === 1'b1) erase_seen = {1'b1, erase_page};
      if (cycles == 20000) begin
         failures++;
         conclude();
      end
   end
   ////////////////////////////////////////////////////////////////
   // shared tasks
   task automatic conclude();
      $display("tests %0d failures %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         failures++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic reg_write(input logic [15:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic reg_check(input string what, input logic [15:0] a, input logic [7:0] exp);
      @(posedge ref_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1;
      check(what, 32'(reg_rdata), 32'(exp));
   endtask
   task automatic link(input int n, input logic [63:0] tx);
      @(posedge ref_clk);
      #1.3;
      master.frame(n, tx, rx);
      repeat (12) @(posedge ref_clk);
   endtask
   task automatic erase_try(input logic [PAGE_BITS-1:0] p, input logic ok);
      @(posedge ref_clk);
      cpu_erase_req <= 1'b1;
      cpu_erase_page <= p;
      @(posedge ref_clk);
      cpu_erase_req <= 1'b0;
      #1;
      check("erase_req", 32'(erase_req), 32'(ok));
      check("erase_deny", 32'(erase_deny), 32'(!ok));
      if (ok) check("erase_page", 32'(erase_page), 32'(p));
   endtask
   task automatic ice_try(input logic locked);
      @(posedge ref_clk);
      ice_rd_req <= 1'b1;
      @(posedge ref_clk);
      ice_rd_req <= 1'b0;
      #1;
      check("ice_rd_grant", 32'(ice_rd_grant), 32'(!locked));
      check("ice_rd_deny", 32'(ice_rd_deny), 32'(locked));
   endtask
   ////////////////////////////////////////////////////////////////
   // scenarios
   task automatic t_reset();
      #1;
      check("seg_oe idle", 32'(seg_oe), 32'h0);
      reg_check("port reg", ADDR_PORT, 8'(RST_PORT_EN) << PORT_EN_BIT);
      reg_check("lock reg", ADDR_LOCK, 8'h00);
      reg_check("command reg", ADDR_CMD, RST_CMD);
      reg_check("unmapped", 16'h1234, 8'h00);
   endtask
   task automatic t_write();
      wr_log.delete();
      link(5, {8'h00, 8'h01, 8'h05, 8'haa, 8'hbb, 24'h0});
      check("write count", 32'(wr_log.size()), 32'd2);
      check("write 0", 32'(wr_log[0]), 32'h0105aa);
      check("write 1", 32'(wr_log[1]), 32'h0106bb);
      reg_check("status clean", ADDR_STAT, 8'h00);
   endtask
   task automatic t_read();
      last_rd_addr = 16'hffff;
      link(5, {8'h80, 8'h00, 8'h03, 8'h00, 8'h00, 24'h0});
      check("read data", 32'(rx[31:24]), 32'(mem_rdata));
      check("read addr", 32'(last_rd_addr), 32'h0003);
      check("read flash", 32'(rd_flash), 32'h0);
      reg_check("command reg", ADDR_CMD, 8'h80);
   endtask
   task automatic t_safe();
      reg_write(ADDR_PORT, 8'h18);
      reg_check("port reg", ADDR_PORT, 8'h18);
      wr_log.delete();
      link(5, {8'h00, 8'h00, 8'h0f, 8'h11, 8'h22, 24'h0});
      link(4, {8'h00, 8'h01, 8'h05, 8'h33, 32'h0});
      check("safe count", 32'(wr_log.size()), 32'd1);
      check("safe write", 32'(wr_log[0]), 32'h000f11);
      reg_check("status refused", ADDR_STAT, 8'h01);
      reg_write(ADDR_STAT, 8'hff);
      reg_check("status cleared", ADDR_STAT, 8'h00);
      reg_write(ADDR_PORT, 8'h10);
   endtask
   task automatic t_lock();
      ice_try(1'b0);
      reg_write(ADDR_LOCK, 8'h40);
      reg_check("lock reg", ADDR_LOCK, 8'h40);
      ice_try(1'b1);
      link(5, {8'hc0, 8'h01, 8'h00, 8'h00, 8'h00, 24'h0});
      check("locked flash read", 32'(rx[31:24]), 32'h0);
      reg_check("status read refused", ADDR_STAT, 8'h02);
      erase_seen = 8'h00;
      link(3, {8'h60, 8'h00, 8'h00, 40'h0});
      check("locked link erase", 32'(erase_seen), 32'h0);
      reg_check("status erase refused", ADDR_STAT, 8'h06);
      erase_try(7'd0, 1'b0);
      erase_try(7'd1, 1'b1);
      erase_try(7'd19, 1'b1);
      erase_try(7'd20, 1'b0);
      erase_try(7'd127, 1'b0);
      reg_write(ADDR_LOCK, 8'h00);
      erase_seen = 8'h00;
      link(3, {8'h60, 8'h00, 8'h05, 40'h0});
      check("link erase", 32'(erase_seen), 32'h85);
      last_rd_addr = 16'hffff;
      link(5, {8'hc0, 8'h01, 8'h00, 8'h00, 8'h00, 24'h0});
      check("flash read data", 32'(rx[31:24]), 32'(mem_rdata));
      check("flash read addr", 32'({rd_flash, last_rd_addr}), 32'h10100);
      erase_try(7'd0, 1'b1);
      erase_try(7'd20, 1'b1);
   endtask
   task automatic t_pins();
      reg_write(ADDR_PORT, 8'h00);
      repeat (4) @(posedge ref_clk);
      #1;
      check("seg_oe off", 32'(seg_oe), 32'hf);
      check("seg_out off", 32'(seg_out), 32'(lcd_seg_out));
      reg_write(ADDR_PORT, 8'h10);
      repeat (4) @(posedge ref_clk);
      #1;
      check("seg_oe on", 32'(seg_oe), 32'h0);
   endtask
   ////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      rstn = 1'b0;
      ce = 1'b1;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 16'h0;
      reg_wdata = 8'h0;
      lcd_seg_out = 4'ha;
      mem_rdata = 8'h5c;
      engine_code_location = 7'd20;
      cpu_erase_req = 1'b0;
      cpu_erase_page = 7'd0;
      ice_rd_req = 1'b0;
      repeat (4) @(posedge ref_clk);
      rstn <= 1'b1;
      t_reset();
      t_write();
      t_read();
      t_safe();
      t_lock();
      t_pins();
      conclude();
   end
endmodule
